/* bench/safety_link_sva.sv */
module safety_link_sva #(
   parameter int NCH = 8
) (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           srst,
   // Controller to module
   input  wire logic           frameStb,
   input  wire logic           frameGood,
   input  wire logic [NCH-1:0] chanEn,
   input  wire logic           autoReint,
   input  wire logic           ackStb,
   // Module to controller
   input  wire logic           rspStb,
   input  wire logic [NCH-1:0] inState,
   input  wire logic [NCH-1:0] chanPas,
   input  wire logic [NCH-1:0] faultNow,
   input  wire logic           lockNow,
   input  wire logic           commErr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   rsp_after_frame_a: assert property (frameStb |=> rspStb)
      else $error("response strobe missing after frame");
   rsp_cause_a: assert property (rspStb |-> $past(frameStb))
      else $error("response strobe without frame");
   frame_spacing_a: assert property (frameStb |=> !frameStb [*8])
      else $error("frames too close together");
   ack_pulse_a: assert property (ackStb |=> !ackStb)
      else $error("acknowledge strobe longer than one cycle");
   bad_frame_a: assert property (frameStb && !frameGood |->
      ##[1:3] commErr)
      else $error("corrupt frame not flagged");
   start_safe_a: assert property ($fell(srst) |-> chanPas == '1 &&
      inState == '0 && !commErr)
      else $error("not in safe state after reset");
   pas_input_a: assert property (
      (inState & chanPas & $past(chanPas)) == '0)
      else $error("passivated input delivers one");
   fault_pas_a: assert property ((faultNow & $past(faultNow) &
      $past(faultNow, 2) & ~chanPas) == '0)
      else $error("faulty channel not passivated");
   pas_hold_a: assert property ((($past(chanPas) & ~chanPas) &
      $past(faultNow)) == '0)
      else $error("passivation left while fault present");
   reint_cause_a: assert property ((|($past(chanPas) & ~chanPas)) |->
      $past(autoReint, 2) || $past(ackStb, 2))
      else $error("reintegration without auto mode or acknowledge");
   lock_hold_a: assert property (lockNow |=> lockNow)
      else $error("lock released without reset");
   disabled_quiet_a: assert property ((faultNow & ~chanEn &
      ~$past(chanEn) & ~$past(chanEn, 2)) == '0)
      else $error("disabled channel reports fault");
endmodule // safety_link_sva

/* bench/testbench.sv */
module testbench import fsafe_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NCH = 8;
   localparam int DARK = 8;
   localparam int LIMIT = 5000;
   localparam logic [31:0] STOP = 32'h1 << CTRL_STOP;
   localparam logic [31:0] AUTO = 32'h1 << CTRL_AUTO;
   localparam logic [31:0] MODSC = 32'h1 << CTRL_MODULE;
   localparam logic [31:0] ACK = 32'h1 << CTRL_ACK;
   localparam logic [31:0] CORRUPT = 32'h1 << CTRL_CORRUPT;
   localparam logic [31:0] HOLD = 32'h1 << CTRL_HOLD;

   logic           clk, srst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]     paddr, seed;
   logic [31:0]    pwdata, prdata, lockSt;
   logic [NCH-1:0] inPin, faultPin, lockPin, outPin, cmd, inp, chBit;
   logic           moduleFaultPin, passivated;
   logic [32:0]    expQ[$];
   int             failCount, checks, cyc, darkRun, maxDark;

   safety_link_if #(.NCH(NCH)) link ();
   safety_controller_end #(.NCH(NCH), .FRAME_PER(16)) safety_controller_end_i (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link.controller));
   io_module_end #(.NCH(NCH), .PERIOD_CYC(64), .DARK_CYC(DARK),
      .TIMEOUT_CYC(40)) io_module_end_i (
      .clk(clk), .srst(srst), .link(link.device), .inPin(inPin),
      .faultPin(faultPin), .lockPin(lockPin), .moduleFaultPin(moduleFaultPin),
      .outPin(outPin), .passivated(passivated));
   safety_link_sva #(.NCH(NCH)) safety_link_sva_i (
      .clk(clk), .srst(srst), .frameStb(link.frameStb),
      .frameGood(link.frameGood), .chanEn(link.chanEn),
      .autoReint(link.autoReint), .ackStb(link.ackStb),
      .rspStb(link.rspStb), .inState(link.inState), .chanPas(link.chanPas),
      .faultNow(link.faultNow), .lockNow(link.lockNow),
      .commErr(link.commErr));

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checks, failCount);
      if (failCount == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic compare(input logic [32:0] got, input logic [32:0] exp);
      checks++;
      if (got !== exp) begin
         failCount++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // One enabled output may sit in its test dark time
   task automatic cmp_pins(input logic [NCH-1:0] got,
                           input logic [NCH-1:0] exp);
      checks++;
      if ((^got === 1'bx) || (got & ~exp) != '0 ||
          $countones(got ^ exp) > 1) begin
         failCount++;
         $display("Error at %0t: pins %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk iff pready === 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic err = 1'b0);
      expQ.push_back({err, e});
      apb(1'b0, a, 32'h0);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Read results are matched against the oldest note
   always @(posedge clk iff (psel && penable && pready === 1'b1 &&
                             !pwrite)) begin
      if (expQ.size() == 0) begin
         failCount++;
         $display("Error at %0t: unexpected read", $time);
      end else
         compare({pslverr, prdata}, expQ.pop_front());
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         failCount++;
         wrap_up();
      end
   end

   // Length of the longest unexplained off time of a commanded output
   always @(posedge clk) begin
      if (srst || passivated !== 1'b0 || link.stopMode ||
          (link.outCmd & link.chanEn & ~outPin) == '0)
         darkRun <= 0;
      else
         darkRun <= darkRun + 1;
      if (darkRun > maxDark)
         maxDark <= darkRun;
   end

   initial begin
      srst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {inPin, faultPin, lockPin, moduleFaultPin} = '0;
      {failCount, checks, cyc, darkRun, maxDark} = '0;
      seed = 8'h2b;
      tick(8);
      srst <= 1'b0;
      tick(1);
      rd(REG_STATUS, 32'h0000_00ff);
      cmp_pins(outPin, '0);
      compare({32'h0, passivated}, 33'h1);
      rd(REG_CTRL, CTRL_RST);
      rd(REG_CHEN, CHEN_RST);
      rd(8'h20, 32'h0, 1'b1);
      seed = lfsr(seed);
      inp = seed;
      inPin <= inp;
      cmd = 8'hff;
      wr(REG_CHEN, 32'h0000_00ff);
      wr(REG_OUTCMD, {24'h0, cmd});
      wr(REG_CTRL, AUTO);
      tick(60);
      maxDark = 0;
      rd(REG_STATUS, 32'h0);
      rd(REG_INDATA, {24'h0, inp});
      cmp_pins(outPin, cmd);
      compare({32'h0, passivated}, 33'h0);
      tick(140);
      compare({1'b0, 32'(maxDark)}, {1'b0, 32'(DARK)});
      seed = lfsr(seed);
      chBit = 8'h1 << seed[2:0];
      wr(REG_CTRL, 32'h0);
      wr(REG_FAULT, 32'hffff_ffff);
      faultPin <= chBit;
      tick(20);
      rd(REG_STATUS, {24'h0, chBit});
      rd(REG_FAULT, {24'h0, chBit});
      rd(REG_INDATA, {24'h0, inp & ~chBit});
      cmp_pins(outPin, ~chBit);
      faultPin <= '0;
      tick(60);
      rd(REG_STATUS, {24'h0, chBit});
      wr(REG_CTRL, ACK);
      tick(40);
      rd(REG_STATUS, 32'h0);
      wr(REG_FAULT, 32'hffff_ffff);
      wr(REG_CHEN, {24'h0, ~chBit});
      faultPin <= chBit;
      tick(20);
      rd(REG_FAULT, 32'h0);
      faultPin <= '0;
      wr(REG_CHEN, 32'h0000_00ff);
      wr(REG_CTRL, AUTO | MODSC);
      faultPin <= chBit;
      tick(20);
      rd(REG_STATUS, 32'h0000_00ff);
      cmp_pins(outPin, '0);
      faultPin <= '0;
      wr(REG_CTRL, AUTO);
      moduleFaultPin <= 1'b1;
      tick(20);
      rd(REG_STATUS, 32'h0000_00ff);
      moduleFaultPin <= 1'b0;
      tick(60);
      rd(REG_STATUS, 32'h0);
      seed = lfsr(seed);
      cmd = seed;
      wr(REG_OUTCMD, {24'h0, cmd});
      wr(REG_CTRL, AUTO | STOP);
      tick(4);
      cmp_pins(outPin, '0);
      wr(REG_CTRL, AUTO);
      tick(6);
      cmp_pins(outPin, cmd);
      wr(REG_CTRL, CORRUPT);
      tick(40);
      rd(REG_STATUS, 32'h0001_0000);
      cmp_pins(outPin, '0);
      cmp_pins(link.inState, inp);
      rd(REG_INDATA, 32'h0);
      wr(REG_CTRL, 32'h0);
      tick(60);
      cmp_pins(outPin, '0);
      wr(REG_CTRL, ACK);
      tick(40);
      cmp_pins(outPin, cmd);
      // Withheld frames must trip the watchdog
      wr(REG_CTRL, HOLD);
      tick(60);
      rd(REG_STATUS, 32'h0001_0000);
      cmp_pins(outPin, '0);
      compare({32'h0, passivated}, 33'h1);
      wr(REG_CTRL, AUTO);
      faultPin <= chBit;
      lockPin <= chBit;
      lockSt = 32'h0002_0000 | {24'h0, chBit};
      tick(20);
      rd(REG_STATUS, lockSt);
      faultPin <= '0;
      lockPin <= '0;
      tick(60);
      rd(REG_STATUS, lockSt);
      srst <= 1'b1;
      tick(2);
      srst <= 1'b0;
      tick(1);
      rd(REG_STATUS, 32'h0000_00ff);
      tick(4);
      wrap_up();
   end
endmodule // testbench

/* include/fsafe_pkg.sv */
package fsafe_pkg;
   // Clock rate
   localparam int CLK_HZ          = 25_000_000;
   localparam int CLK_PER_US      = CLK_HZ / 1_000_000;
   // Output test pulse: dark time held under 1 ms, repeat period
   localparam int DARK_LIMIT_US   = 1000;
   localparam int TEST_DARK_US    = 900;
   localparam int TEST_PERIOD_US  = 100_000;
   localparam int DARK_LIMIT_CYC  = DARK_LIMIT_US * CLK_PER_US;
   localparam int TEST_DARK_CYC   = TEST_DARK_US * CLK_PER_US;
   localparam int TEST_PERIOD_CYC = TEST_PERIOD_US * CLK_PER_US;
   // Safety frame timing
   localparam int COMM_TIMEOUT_US  = 1000;
   localparam int COMM_TIMEOUT_CYC = COMM_TIMEOUT_US * CLK_PER_US;
   localparam int FRAME_US         = 200;
   localparam int FRAME_CYC        = FRAME_US * CLK_PER_US;
   // Channel count
   localparam int NCH_DEF = 8;
   // Controller register offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_CHEN   = 8'h04;
   localparam logic [7:0] REG_OUTCMD = 8'h08;
   localparam logic [7:0] REG_INDATA = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_FAULT  = 8'h14;
   // CTRL bit positions
   localparam int CTRL_STOP    = 0;
   localparam int CTRL_AUTO    = 1;
   localparam int CTRL_MODULE  = 2;
   localparam int CTRL_ACK     = 3;
   localparam int CTRL_CORRUPT = 4;
   localparam int CTRL_HOLD    = 5;
   // STATUS / FAULT: channel bits low, comm error and lock bits here
   localparam int STAT_COMM    = 16;
   localparam int STAT_LOCK    = 17;
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CHEN_RST = 32'h0000_0000;
endpackage

/* include/safety_link_if.sv */
interface safety_link_if #(parameter int NCH = 8);
   // Controller to module
   logic             frameStb;
   logic             frameGood;
   logic [NCH-1:0]   outCmd;
   logic [NCH-1:0]   chanEn;
   logic             stopMode;
   logic             autoReint;
   logic             moduleScope;
   logic             ackStb;
   // Module to controller
   logic             rspStb;
   logic [NCH-1:0]   inState;
   logic [NCH-1:0]   chanPas;
   logic [NCH-1:0]   faultNow;
   logic             lockNow;
   logic             commErr;

   modport device (
      input  frameStb, frameGood, outCmd, chanEn, stopMode, autoReint,
             moduleScope, ackStb,
      output rspStb, inState, chanPas, faultNow, lockNow, commErr
   );
   modport controller (
      output frameStb, frameGood, outCmd, chanEn, stopMode, autoReint,
             moduleScope, ackStb,
      input  rspStb, inState, chanPas, faultNow, lockNow, commErr
   );
endinterface

/* src/io_module_end.sv */
// Functional notes
// - Test enabled outputs with off pulses under 1 ms
// - Safe state of every channel is 0
// - Safe values at startup until reintegration
// - Communication error passivates process data
// - Channel or module fault passivates affected channels
// - Every detected fault is reported to controller
// - No fault record survives power cycle
// - Disabled channels cause no fault handling
// - Passivated inputs deliver 0
// - Passivated outputs drive 0
// - Controller stop mode forces outputs to 0
// - Substitute value fixed at 0, not configurable
// - Passivation scope is channel or whole module
// - Reintegration automatic or after acknowledgment
// - Some faults block reintegration until reinsertion
// - After reintegration inputs deliver real states
// - After reintegration outputs follow commands
// - Comm error: inputs keep sending, controller passivates
// - Unacknowledged comm error keeps outputs at 0 (with autoReint set, outputs resume after good frames without acknowledgment)
//
// Chosen here: the placing of the registers and the APB interface to the registers.
module io_module_end
   import fsafe_pkg::*;
#(
   parameter int NCH         = NCH_DEF,
   parameter int PERIOD_CYC  = TEST_PERIOD_CYC,
   parameter int DARK_CYC    = TEST_DARK_CYC,
   parameter int TIMEOUT_CYC = COMM_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           srst,
   // Safety link
   safety_link_if.device       link,
   // Process pins
   input  wire logic [NCH-1:0] inPin,
   input  wire logic [NCH-1:0] faultPin,
   input  wire logic [NCH-1:0] lockPin,
   input  wire logic           moduleFaultPin,
   output logic      [NCH-1:0] outPin,
   output logic                passivated
);
   localparam int RAW = 3 * NCH + 1;
   localparam int CW  = 32;

   if (NCH < 1 || NCH > 16) begin : g_chk_nch
      $error("NCH must be 1 to 16");
   end
   if (DARK_CYC < 1 || DARK_CYC >= DARK_LIMIT_CYC) begin : g_chk_dark
      $error("Dark time must stay under 1 ms");
   end
   if (PERIOD_CYC <= DARK_CYC || TIMEOUT_CYC < 2) begin : g_chk_per
      $error("Period or timeout too short");
   end

   // Pin synchronisers: value accepted when stages two and three agree
   logic [RAW-1:0] raw;
   logic [RAW-1:0] s1_q;
   logic [RAW-1:0] s2_q;
   logic [RAW-1:0] s3_q;
   logic [RAW-1:0] pin_q;

   assign raw = {moduleFaultPin, lockPin, faultPin, inPin};

   for (genvar b = 0; b < RAW; b++) begin : g_sync
      always_ff @(posedge clk) begin
         if (srst) begin
            s1_q[b]  <= 1'b0;
            s2_q[b]  <= 1'b0;
            s3_q[b]  <= 1'b0;
            pin_q[b] <= 1'b0;
         end else begin
            s1_q[b] <= raw[b];
            s2_q[b] <= s1_q[b];
            s3_q[b] <= s2_q[b];
            if (s2_q[b] == s3_q[b]) begin
               pin_q[b] <= s3_q[b];
            end
         end
      end
   end

   logic [NCH-1:0] inVal;
   logic [NCH-1:0] fltVal;
   logic [NCH-1:0] lckVal;
   logic           modFlt;
   assign inVal  = pin_q[NCH-1:0];
   assign fltVal = pin_q[2*NCH-1:NCH];
   assign lckVal = pin_q[3*NCH-1:2*NCH];
   assign modFlt = pin_q[RAW-1];

   // Fault qualification and passivation scope
   logic [NCH-1:0] fltEn;
   logic [NCH-1:0] lckEn;
   logic [NCH-1:0] trip;
   logic [NCH-1:0] lock_q;
   logic [NCH-1:0] pas_q;
   logic           commErr_q;
   logic           goodSeen_q;
   logic           commPas_q;
   logic           reintOk;
   logic [NCH-1:0] chanOk;

   assign fltEn = fltVal & link.chanEn;
   assign lckEn = lckVal & link.chanEn;

   always_comb begin
      if (link.moduleScope) begin
         trip = {NCH{(|(fltEn | lckEn)) | modFlt}};
      end else begin
         trip = fltEn | lckEn | {NCH{modFlt}};
      end
   end

   // Reintegration permission: automatic or acknowledged
   assign reintOk = link.autoReint | link.ackStb;

   always_comb begin
      if (link.moduleScope) begin
         chanOk = {NCH{~(|(fltEn | lock_q)) & ~modFlt}};
      end else begin
         chanOk = ~fltEn & ~lock_q & {NCH{~modFlt}};
      end
   end

   // Severe faults latch until reset, i.e. removal and reinsertion
   always_ff @(posedge clk) begin
      if (srst) begin
         lock_q <= '0;
      end else begin
         lock_q <= lock_q | lckEn;
      end
   end

   // Channel passivation: set at startup, set wins over clear
   always_ff @(posedge clk) begin
      if (srst) begin
         pas_q <= '1;
      end else if (reintOk && goodSeen_q) begin
         pas_q <= (pas_q & ~chanOk) | trip;
      end else begin
         pas_q <= pas_q | trip;
      end
   end

   // Communication watchdog
   logic [CW-1:0] wdCnt_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         wdCnt_q   <= '0;
         commErr_q <= 1'b0;
      end else if (link.frameStb && link.frameGood) begin
         wdCnt_q   <= '0;
         commErr_q <= 1'b0;
      end else if (link.frameStb) begin
         commErr_q <= 1'b1;
      end else if (wdCnt_q >= CW'(TIMEOUT_CYC - 1)) begin
         commErr_q <= 1'b1;
      end else begin
         wdCnt_q <= wdCnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         goodSeen_q <= 1'b0;
      end else if (commErr_q) begin
         goodSeen_q <= 1'b0;
      end else if (link.frameStb && link.frameGood) begin
         goodSeen_q <= 1'b1;
      end
   end

   // Output data passivation on comm error, held until reintegration
   always_ff @(posedge clk) begin
      if (srst) begin
         commPas_q <= 1'b1;
      end else if (commErr_q) begin
         commPas_q <= 1'b1;
      end else if (goodSeen_q && reintOk) begin
         commPas_q <= 1'b0;
      end
   end

   // Periodic output test: one channel at a time is switched dark
   localparam int TW = $clog2(NCH + 1);

   logic [CW-1:0]  perCnt_q;
   logic [CW-1:0]  darkCnt_q;
   logic           dark_q;
   logic [TW-1:0]  testCh_q;
   logic [NCH-1:0] testOff;

   always_ff @(posedge clk) begin
      if (srst) begin
         perCnt_q  <= '0;
         darkCnt_q <= '0;
         dark_q    <= 1'b0;
         testCh_q  <= '0;
      end else if (dark_q) begin
         if (darkCnt_q >= CW'(DARK_CYC - 1)) begin
            dark_q    <= 1'b0;
            darkCnt_q <= '0;
            testCh_q  <= (testCh_q == TW'(NCH - 1)) ?
                         '0 : testCh_q + 1'b1;
         end else begin
            darkCnt_q <= darkCnt_q + 1'b1;
         end
      end else if (perCnt_q >= CW'(PERIOD_CYC - 1)) begin
         perCnt_q <= '0;
         dark_q   <= 1'b1;
      end else begin
         perCnt_q <= perCnt_q + 1'b1;
      end
   end

   for (genvar c = 0; c < NCH; c++) begin : g_test
      assign testOff[c] = dark_q && (testCh_q == TW'(c));
   end

   // Output drive: substitute value is the constant 0
   always_ff @(posedge clk) begin
      if (srst) begin
         outPin <= '0;
      end else if (commPas_q || link.stopMode) begin
         outPin <= '0;
      end else begin
         outPin <= link.outCmd & link.chanEn & ~pas_q & ~testOff;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         passivated <= 1'b1;
      end else begin
         passivated <= commPas_q | (|pas_q);
      end
   end

   // Response frame follows every received frame by one cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         link.rspStb   <= 1'b0;
         link.inState  <= '0;
         link.chanPas  <= '1;
         link.faultNow <= '0;
         link.lockNow  <= 1'b0;
         link.commErr  <= 1'b0;
      end else begin
         link.rspStb   <= link.frameStb;
         link.inState  <= inVal & ~pas_q;
         link.chanPas  <= pas_q;
         link.faultNow <= fltEn | lock_q | {NCH{modFlt}};
         link.lockNow  <= |lock_q;
         link.commErr  <= commErr_q;
      end
   end
endmodule // io_module_end

/* src/safety_controller_end.sv */
module safety_controller_end
   import fsafe_pkg::*;
#(
   parameter int NCH       = NCH_DEF,
   parameter int FRAME_PER = FRAME_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Safety link
   safety_link_if.controller link
);
   if (NCH < 1 || NCH > 16 || FRAME_PER < 2) begin : g_chk
      $error("Unsupported NCH or frame period");
   end

   logic [31:0]    ctrl_q;
   logic [NCH-1:0] chen_q;
   logic [NCH-1:0] cmd_q;
   logic [NCH-1:0] inData_q;
   logic [31:0]    fault_q;
   logic [31:0]    frCnt_q;
   logic           wrEn;
   logic           rdEn;
   logic [31:0]    faultSet;

   // One wait state: answer on the second access cycle
   assign wrEn = psel && penable && !pready && pwrite;
   assign rdEn = psel && penable && !pready && !pwrite;

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q <= CTRL_RST;
         chen_q <= CHEN_RST[NCH-1:0];
         cmd_q  <= '0;
      end else if (wrEn) begin
         case (paddr)
            REG_CTRL:   ctrl_q <= pwdata & 32'h0000_0037;
            REG_CHEN:   chen_q <= pwdata[NCH-1:0];
            REG_OUTCMD: cmd_q  <= pwdata[NCH-1:0];
            default:    ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= 1'b0;
         if (rdEn || wrEn) begin
            prdata <= '0;
            case (paddr)
               REG_CTRL:   prdata <= ctrl_q;
               REG_CHEN:   prdata <= 32'(chen_q);
               REG_OUTCMD: prdata <= 32'(cmd_q);
               REG_INDATA: prdata <= 32'(inData_q);
               REG_STATUS: prdata <= 32'(link.chanPas)
                  | (32'(link.commErr) << STAT_COMM)
                  | (32'(link.lockNow) << STAT_LOCK);
               REG_FAULT:  prdata <= fault_q;
               default:    pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Diagnostic buffer: sticky, write one to clear, new event wins
   assign faultSet = link.rspStb ? (32'(link.faultNow)
                     | (32'(link.commErr) << STAT_COMM)
                     | (32'(link.lockNow) << STAT_LOCK)) : '0;

   always_ff @(posedge clk) begin
      if (srst) begin
         fault_q <= '0;
      end else if (wrEn && paddr == REG_FAULT) begin
         fault_q <= (fault_q & ~pwdata) | faultSet;
      end else begin
         fault_q <= fault_q | faultSet;
      end
   end

   // Input data to program: zeroed here when a response reports comm error
   always_ff @(posedge clk) begin
      if (srst) begin
         inData_q <= '0;
      end else if (link.rspStb) begin
         inData_q <= link.commErr ? '0 : link.inState;
      end
   end

   // Frame generator and link drive
   always_ff @(posedge clk) begin
      if (srst) begin
         frCnt_q         <= '0;
         link.frameStb   <= 1'b0;
         link.frameGood  <= 1'b0;
      end else begin
         link.frameStb <= 1'b0;
         if (frCnt_q >= 32'(FRAME_PER - 1)) begin
            frCnt_q <= '0;
            if (!ctrl_q[CTRL_HOLD]) begin
               link.frameStb  <= 1'b1;
               link.frameGood <= !ctrl_q[CTRL_CORRUPT];
            end
         end else begin
            frCnt_q <= frCnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         link.outCmd      <= '0;
         link.chanEn      <= '0;
         link.stopMode    <= 1'b0;
         link.autoReint   <= 1'b0;
         link.moduleScope <= 1'b0;
         link.ackStb      <= 1'b0;
      end else begin
         link.outCmd      <= cmd_q;
         link.chanEn      <= chen_q;
         link.stopMode    <= ctrl_q[CTRL_STOP];
         link.autoReint   <= ctrl_q[CTRL_AUTO];
         link.moduleScope <= ctrl_q[CTRL_MODULE];
         link.ackStb      <= wrEn && paddr == REG_CTRL
                             && pwdata[CTRL_ACK];
      end
   end
endmodule // safety_controller_end
